// ===== pkg/irf_map.svh
// register offsets, field positions and reset values of the request flag block
`ifndef IRF_MAP_SVH
`define IRF_MAP_SVH
`define IRF_OFS_FLAGS_ONE   12'h000
`define IRF_OFS_FLAGS_TWO   12'h004
`define IRF_OFS_WAKEUP      12'h008
`define IRF_OFS_ENABLE_ONE  12'h00c
`define IRF_OFS_ENABLE_TWO  12'h010
`define IRF_OFS_EDGE_SEL    12'h014
`define IRF_OFS_PIN_FUNC    12'h018
`define IRF_RSV_BIT         5
`define IRF_ONE_MASK        8'hdf
`define IRF_RST_FLAGS       8'h00
`define IRF_RST_CTRL        8'h00
`endif

// ===== pkg/irf_pkg.sv
// types shared by the request flag block
package irf_pkg;
    // one-cycle event strobes from the peripherals
    typedef struct packed {
        logic timer_a_ovf;
        logic serial_one_done;
        logic direct_xfer;
        logic adc_done;
        logic serial_two_done;
        logic serial_two_abort;
        logic fh_match;
        logic fl_match;
        logic timer_c_ovf;
        logic timer_c_udf;
        logic timer_b_ovf;
    } irf_events_t;
    // pin levels of the interrupt, capture and wakeup pins
    typedef struct packed {
        logic [4:0] ext_pin;
        logic       capture_timer_pin;
        logic [7:0] wakeup_pin;
    } irf_pins_t;
endpackage

// ===== hdl/irf_flags.sv
// interrupt request flag registers with ahb-lite slave
`include "irf_map.svh"
`timescale 1ns/10ps
`default_nettype none
module irf_flags (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic [11:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hsel,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire irf_pkg::irf_events_t ev,
    input  wire irf_pkg::irf_pins_t   pins,
    input  wire logic               direct_xfer_on,
    input  wire logic               adc_start_flag,
    input  wire logic               timer_f_16bit,
    input  wire logic               capture_edge_rise,
    output logic      [7:0]         flags_one,
    output logic      [7:0]         flags_two,
    output logic      [7:0]         wakeup_flags,
    output logic      [7:0]         req_one,
    output logic      [7:0]         req_two
);
    logic       rs1_q, rs2_q;
    logic [7:0] flags_one_q, flags_two_q, wakeup_q;
    logic [7:0] en_one_q, en_two_q, pin_func_q;
    logic [4:0] edge_sel_q;
    logic [4:0] ext_prev_q;
    logic       cap_prev_q;
    logic [7:0] wk_prev_q;
    logic       wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [7:0] set_one, set_two, set_wk;
    logic [7:0] clr_one, clr_two, clr_wk, clr_en_wk;
    logic       take;
    logic [4:0] set_ext;

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end

    // edge check on one pin level
    function automatic logic edge_seen(input logic prev, input logic cur,
                                       input logic rise);
        edge_seen = rise ? (!prev && cur) : (prev && !cur);
    endfunction

    // previous pin levels for edge detection
    always_ff @(posedge clk or negedge rs2_q) begin
        if (!rs2_q) begin
            ext_prev_q <= 5'h00;
            cap_prev_q <= 1'b0;
            wk_prev_q  <= 8'hff;
        end else begin
            ext_prev_q <= pins.ext_pin;
            cap_prev_q <= pins.capture_timer_pin;
            wk_prev_q  <= pins.wakeup_pin;
        end
    end

    // set conditions per flag
    always_comb begin
        // bit 5 never sets here, it is forced on read
        set_one = {ev.timer_a_ovf,
                   ev.serial_one_done,
                   1'b0,
                   set_ext};
        set_two[7] = direct_xfer_on && ev.direct_xfer;
        set_two[6] = ev.adc_done && !adc_start_flag;
        set_two[5] = ev.serial_two_done || ev.serial_two_abort;
        set_two[4] = pin_func_q[5]
            && edge_seen(cap_prev_q, pins.capture_timer_pin,
                         capture_edge_rise);
        set_two[3] = ev.fh_match;
        set_two[2] = ev.fl_match && !timer_f_16bit;
        set_two[1] = ev.timer_c_ovf || ev.timer_c_udf;
        set_two[0] = ev.timer_b_ovf;
    end

    // external and wakeup pin edges
    for (genvar i = 0; i < 5; i++) begin : g_ext
        assign set_ext[i] = pin_func_q[i]
            && edge_seen(ext_prev_q[i], pins.ext_pin[i], edge_sel_q[i]);
    end
    for (genvar i = 0; i < 8; i++) begin : g_wk
        assign set_wk[i] = clr_en_wk[i]
            && edge_seen(wk_prev_q[i], pins.wakeup_pin[i], 1'b0);
    end

    // ahb address phase capture
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge clk or negedge rs2_q) begin
        if (!rs2_q) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= take && hwrite;
            wr_addr_q <= haddr;
        end
    end

    // write of 0 clears, 1 keeps
    assign clr_one = (wr_pend_q && wr_addr_q == `IRF_OFS_FLAGS_ONE)
                     ? ~hwdata[7:0] : 8'h00;
    assign clr_two = (wr_pend_q && wr_addr_q == `IRF_OFS_FLAGS_TWO)
                     ? ~hwdata[7:0] : 8'h00;
    assign clr_wk  = (wr_pend_q && wr_addr_q == `IRF_OFS_WAKEUP)
                     ? ~hwdata[7:0] : 8'h00;
    // wakeup pins 7..6 share bits 7..6 of the pin function register, pins 5..0 are always on
    assign clr_en_wk = {pin_func_q[7:6], 6'h3f};

    // flag registers: set wins, only writes clear
    always_ff @(posedge clk or negedge rs2_q) begin
        if (!rs2_q) begin
            flags_one_q <= `IRF_RST_FLAGS;
            flags_two_q <= `IRF_RST_FLAGS;
            wakeup_q    <= `IRF_RST_FLAGS;
        end else begin
            flags_one_q <= ((flags_one_q & ~clr_one) | set_one)
                           & `IRF_ONE_MASK;
            flags_two_q <= (flags_two_q & ~clr_two) | set_two;
            wakeup_q    <= (wakeup_q & ~clr_wk) | set_wk;
        end
    end

    // control registers: enables, edge select, pin function
    always_ff @(posedge clk or negedge rs2_q) begin
        if (!rs2_q) begin
            en_one_q   <= `IRF_RST_CTRL;
            en_two_q   <= `IRF_RST_CTRL;
            edge_sel_q <= 5'h00;
            pin_func_q <= `IRF_RST_CTRL;
        end else if (wr_pend_q) begin
            if (wr_addr_q == `IRF_OFS_ENABLE_ONE) en_one_q <= hwdata[7:0];
            if (wr_addr_q == `IRF_OFS_ENABLE_TWO) en_two_q <= hwdata[7:0];
            if (wr_addr_q == `IRF_OFS_EDGE_SEL)  edge_sel_q <= hwdata[4:0];
            if (wr_addr_q == `IRF_OFS_PIN_FUNC)  pin_func_q <= hwdata[7:0];
        end
    end

    // read data, registered on the address phase
    always_ff @(posedge clk or negedge rs2_q) begin
        if (!rs2_q) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            unique case (haddr)
                `IRF_OFS_FLAGS_ONE:  hrdata <= {24'h0, flags_one_q
                                     | 8'h20};
                `IRF_OFS_FLAGS_TWO:  hrdata <= {24'h0, flags_two_q};
                `IRF_OFS_WAKEUP:     hrdata <= {24'h0, wakeup_q};
                `IRF_OFS_ENABLE_ONE: hrdata <= {24'h0, en_one_q};
                `IRF_OFS_ENABLE_TWO: hrdata <= {24'h0, en_two_q};
                `IRF_OFS_EDGE_SEL:   hrdata <= {27'h0, edge_sel_q};
                `IRF_OFS_PIN_FUNC:   hrdata <= {24'h0, pin_func_q};
                default:             hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // outputs straight from flops; requests gated by enables
    always_ff @(posedge clk or negedge rs2_q) begin
        if (!rs2_q) begin
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            flags_one    <= 8'h20;
            flags_two    <= 8'h00;
            wakeup_flags <= 8'h00;
            req_one      <= 8'h00;
            req_two      <= 8'h00;
        end else begin
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            flags_one    <= flags_one_q | 8'h20;
            flags_two    <= flags_two_q;
            wakeup_flags <= wakeup_q;
            req_one      <= {flags_one_q[7:6] & en_one_q[7:6],
                             en_one_q[5] & (|wakeup_q),
                             flags_one_q[4:0] & en_one_q[4:0]};
            req_two      <= flags_two_q & en_two_q;
        end
    end

    // a flag never drops without a clearing write
    property p_no_auto_clear;
        @(posedge clk) disable iff (!rs2_q)
        (flags_two_q[0] && !(wr_pend_q && wr_addr_q == `IRF_OFS_FLAGS_TWO))
        |=> flags_two_q[0];
    endproperty
    a_no_auto_clear: assert property (p_no_auto_clear)
        else $error("flag cleared without write");

    // a set in the same cycle as a clear still lands
    property p_set_wins;
        @(posedge clk) disable iff (!rs2_q)
        set_one[7] |=> flags_one_q[7];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("set lost");

    // reserved bit shows 1 and never holds state
    property p_rsv;
        @(posedge clk) disable iff (!rs2_q) flags_one[5] && !flags_one_q[5];
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bit wrong");

    // request output is flag and enable of the cycle before
    property p_req;
        @(posedge clk) disable iff (!rs2_q)
        1'b1 |=> req_two == ($past(flags_two_q) & $past(en_two_q));
    endproperty
    a_req: assert property (p_req)
        else $error("request not gated by enable");

    // a write of 0 with no set clears the flag
    property p_wr_clear;
        @(posedge clk) disable iff (!rs2_q)
        (wr_pend_q && wr_addr_q == `IRF_OFS_FLAGS_TWO && !hwdata[0]
         && !set_two[0]) |=> !flags_two_q[0];
    endproperty
    a_wr_clear: assert property (p_wr_clear)
        else $error("write of 0 did not clear");

    // software writes never set a flag
    property p_wr_no_set;
        @(posedge clk) disable iff (!rs2_q)
        (wr_pend_q && wr_addr_q == `IRF_OFS_FLAGS_TWO && !flags_two_q[0]
         && !set_two[0]) |=> !flags_two_q[0];
    endproperty
    a_wr_no_set: assert property (p_wr_no_set)
        else $error("write set a flag");

    // selected edge on an interrupt pin sets its flag
    property p_ext_edge;
        @(posedge clk) disable iff (!rs2_q)
        (pin_func_q[0] && (edge_sel_q[0]
            ? (!ext_prev_q[0] && pins.ext_pin[0])
            : (ext_prev_q[0] && !pins.ext_pin[0]))) |=> flags_one_q[0];
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("external edge missed");

    // pin not in interrupt use never sets its flag
    property p_ext_gate;
        @(posedge clk) disable iff (!rs2_q)
        (!pin_func_q[0] && !flags_one_q[0]) |=> !flags_one_q[0];
    endproperty
    a_ext_gate: assert property (p_ext_gate)
        else $error("external flag set while pin unused");

    // falling edge on a wakeup pin sets its flag
    property p_wk_edge;
        @(posedge clk) disable iff (!rs2_q)
        (wk_prev_q[0] && !pins.wakeup_pin[0]) |=> wakeup_q[0];
    endproperty
    a_wk_edge: assert property (p_wk_edge)
        else $error("wakeup edge missed");

    // wakeup pin out of wakeup use never sets its flag
    property p_wk_gate;
        @(posedge clk) disable iff (!rs2_q)
        (!pin_func_q[7] && !wakeup_q[7]) |=> !wakeup_q[7];
    endproperty
    a_wk_gate: assert property (p_wk_gate)
        else $error("wakeup flag set while pin unused");

    // direct transfer flag needs transfer mode on
    property p_dt_gate;
        @(posedge clk) disable iff (!rs2_q)
        (!direct_xfer_on && !flags_two_q[7]) |=> !flags_two_q[7];
    endproperty
    a_dt_gate: assert property (p_dt_gate)
        else $error("direct transfer flag set while off");

    // converter flag needs the start flag reset
    property p_adc_gate;
        @(posedge clk) disable iff (!rs2_q)
        (adc_start_flag && !flags_two_q[6]) |=> !flags_two_q[6];
    endproperty
    a_adc_gate: assert property (p_adc_gate)
        else $error("converter flag set while busy");

    // low compare flag only in 8-bit mode
    property p_fl_gate;
        @(posedge clk) disable iff (!rs2_q)
        (timer_f_16bit && !flags_two_q[2]) |=> !flags_two_q[2];
    endproperty
    a_fl_gate: assert property (p_fl_gate)
        else $error("low compare flag set in 16-bit mode");

    // rising edge on the capture pin, when selected, sets its flag
    property p_cap_edge;
        @(posedge clk) disable iff (!rs2_q)
        (pin_func_q[5] && capture_edge_rise && !cap_prev_q
         && pins.capture_timer_pin) |=> flags_two_q[4];
    endproperty
    a_cap_edge: assert property (p_cap_edge)
        else $error("capture edge missed");

    // capture pin out of capture use never sets its flag
    property p_cap_gate;
        @(posedge clk) disable iff (!rs2_q)
        (!pin_func_q[5] && !flags_two_q[4]) |=> !flags_two_q[4];
    endproperty
    a_cap_gate: assert property (p_cap_gate)
        else $error("capture flag set while pin unused");
endmodule
`default_nettype wire

// ===== verif/irf_periph.sv
// peripheral event source model: one-cycle strobes on request
`timescale 1ns/10ps
`default_nettype none
module irf_periph (
    input  wire logic           go,
    input  wire logic [3:0]     sel,
    output irf_pkg::irf_events_t ev
);
    // one strobe bit per request, high only while go stands
    assign ev = irf_pkg::irf_events_t'(go ? (11'h1 << sel) : 11'h0);
endmodule
`default_nettype wire

// ===== verif/tb_irf_flags.sv
// self-checking bench of the request flag block
`timescale 1ns/10ps
`default_nettype none
`include "irf_map.svh"
module tb_irf_flags;
    logic                 clk = 1'b0;
    logic                 rstn = 1'b0;
    logic                 hwrite = 1'b0;
    logic                 hsel = 1'b0;
    logic                 go = 1'b0;
    logic                 rd_dp = 1'b0;
    logic                 direct_xfer_on = 1'b1;
    logic                 adc_start_flag = 1'b0;
    logic                 timer_f_16bit = 1'b0;
    logic                 capture_edge_rise = 1'b1;
    logic [3:0]           sel = 4'h0;
    logic [1:0]           htrans = 2'h0;
    logic [11:0]          haddr = 12'h000;
    logic [31:0]          hwdata = 32'h0;
    logic [31:0]          hrdata;
    logic [31:0]          r;
    logic                 hreadyout;
    logic [7:0]           req_two;
    logic [7:0]           req_one;
    logic [7:0]           flags_one;
    logic [7:0]           flags_two;
    logic [7:0]           wakeup_flags;
    logic [7:0]           rsv;
    logic [7:0]           expq [$];
    logic [11:0]          a;
    logic [7:0]           m;
    irf_pkg::irf_events_t ev;
    irf_pkg::irf_pins_t   pins = '{5'h00, 1'b0, 8'hff};
    // target register (bit 8 = register one) and flag bit per event index
    logic [8:0]           tbl [0:10] = '{9'h001, 9'h002, 9'h002, 9'h004,
        9'h008, 9'h020, 9'h020, 9'h040, 9'h080, 9'h140, 9'h180};
    integer               seed = 32'h62850ae6;
    integer               miscompares = 0;
    integer               checks = 0;
    integer               cyc = 0;
    integer               i;

    always #12.5 clk = ~clk;

    irf_flags u_dut (.clk(clk), .rstn(rstn), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hsel(hsel),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .ev(ev), .pins(pins), .direct_xfer_on(direct_xfer_on),
        .adc_start_flag(adc_start_flag), .timer_f_16bit(timer_f_16bit),
        .capture_edge_rise(capture_edge_rise), .flags_one(flags_one),
        .flags_two(flags_two), .wakeup_flags(wakeup_flags),
        .req_one(req_one), .req_two(req_two));

    irf_periph u_periph (.go(go), .sel(sel), .ev(ev));

    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, s, e);
        end
    endtask

    // single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] ad, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= ad;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        rd_dp <= !w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] ad, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, ad, 8'h00);
    endtask

    task automatic pulse(input integer k);
        go <= 1'b1;
        sel <= k[3:0];
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask

    // read data compared against the oldest note
    always @(posedge clk)
        if (rd_dp && hreadyout === 1'b1)
            chk(hrdata[7:0], expq.pop_front());

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 8; i++)
            rd(12'(4 * i), (i == 0) ? 8'h20 : 8'h00);
        $display("test reset done");
        for (i = 0; i < 11; i++) begin
            a = tbl[i][8] ? `IRF_OFS_FLAGS_ONE : `IRF_OFS_FLAGS_TWO;
            rsv = tbl[i][8] ? 8'h20 : 8'h00;
            m = tbl[i][7:0] | rsv;
            r = $random(seed);
            pulse(i);
            rd(a, m);
            bus(1'b1, a, r[7:0]);
            rd(a, m & (r[7:0] | rsv));
            bus(1'b1, a, 8'h00);
            rd(a, m & rsv);
        end
        $display("test events done");
        direct_xfer_on <= 1'b0;
        adc_start_flag <= 1'b1;
        timer_f_16bit <= 1'b1;
        pulse(8);
        pulse(7);
        pulse(3);
        rd(`IRF_OFS_FLAGS_TWO, 8'h00);
        $display("test gating done");
        bus(1'b1, `IRF_OFS_PIN_FUNC, 8'h1f);
        bus(1'b1, `IRF_OFS_FLAGS_ONE, 8'h00);
        pins.ext_pin <= 5'h1f;
        repeat (2) @(posedge clk);
        rd(`IRF_OFS_FLAGS_ONE, 8'h20);
        pins.ext_pin <= 5'h00;
        repeat (2) @(posedge clk);
        rd(`IRF_OFS_FLAGS_ONE, 8'h3f);
        bus(1'b1, `IRF_OFS_FLAGS_ONE, 8'h00);
        bus(1'b1, `IRF_OFS_EDGE_SEL, 8'h1f);
        pins.ext_pin <= 5'h1f;
        repeat (2) @(posedge clk);
        rd(`IRF_OFS_FLAGS_ONE, 8'h3f);
        bus(1'b1, `IRF_OFS_PIN_FUNC, 8'hff);
        bus(1'b1, `IRF_OFS_FLAGS_ONE, 8'h00);
        pins.ext_pin <= 5'h00;
        pins.wakeup_pin <= 8'h00;
        pins.capture_timer_pin <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`IRF_OFS_FLAGS_ONE, 8'h20);
        rd(`IRF_OFS_WAKEUP, 8'hff);
        rd(`IRF_OFS_FLAGS_TWO, 8'h10);
        chk(wakeup_flags, 8'hff);
        chk(flags_two, 8'h10);
        chk(req_one, 8'h00);
        bus(1'b1, `IRF_OFS_WAKEUP, 8'h00);
        bus(1'b1, `IRF_OFS_FLAGS_TWO, 8'h00);
        rd(`IRF_OFS_WAKEUP, 8'h00);
        $display("test pins done");
        fork
            bus(1'b1, `IRF_OFS_FLAGS_TWO, 8'h00);
            begin
                @(posedge clk);
                pulse(0);
            end
        join
        rd(`IRF_OFS_FLAGS_TWO, 8'h01);
        chk(flags_one, 8'h20);
        bus(1'b1, `IRF_OFS_ENABLE_TWO, 8'hff);
        rd(`IRF_OFS_ENABLE_TWO, 8'hff);
        repeat (2) @(posedge clk);
        chk(req_two, 8'h01);
        bus(1'b1, `IRF_OFS_FLAGS_TWO, 8'h00);
        repeat (2) @(posedge clk);
        chk(req_two, 8'h00);
        $display("test collide done");
        close_out();
    end
endmodule
`default_nettype wire
